/* File: rtl/ffup_pkg.sv */
// constants for the floating word unpack and pack unit
package ffup_pkg;
	// ----------------------------------------
	// field widths
	// ----------------------------------------
	localparam int SP_MANT_W = 22;
	localparam int DP_MANT_W = 54;
	localparam int EXP_W = 9;
	localparam int MANT_W = 55; // hidden one plus double fraction
	localparam int TEXP_W = 11; // signed true exponent on the pack side

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SP_SIGN_BIT = 31;
	localparam int DP_SIGN_BIT = 63;
	localparam int SP_EXP_LSB = 22;
	localparam int DP_EXP_LSB = 54;
	localparam int SP_EXP_MSB = 30;
	localparam int DP_EXP_MSB = 62;

	// ----------------------------------------
	// exponent coding
	// ----------------------------------------
	localparam logic [EXP_W-1:0] EXP_ZERO_CODE = 9'h000;
	localparam logic [EXP_W-1:0] EXP_SAT_CODE = 9'h1ff;
	localparam logic [9:0] EXP_BIAS10 = 10'h100;
	localparam logic signed [TEXP_W-1:0] EXP_BIAS = 11'sh100;
	localparam logic signed [TEXP_W-1:0] EXP_TRUE_MAX = 11'sh0ff;
	localparam logic signed [TEXP_W-1:0] EXP_TRUE_MIN = -11'sh0ff;

	// ----------------------------------------
	// values after reset and latency
	// ----------------------------------------
	localparam logic [63:0] WORD_RST = 64'h0;
	localparam logic [MANT_W-1:0] MANT_RST = 55'h0;
	localparam int LATENCY_CYC = 1;
endpackage : ffup_pkg

/* File: rtl/ffup_exp_check.sv */
// exponent range check and bias for the pack path
`timescale 1ns/1ps
module ffup_exp_check (
	input wire logic signed [ffup_pkg::TEXP_W-1:0] trueExp,
	output logic [ffup_pkg::EXP_W-1:0] biasedExp,
	output logic overflow,
	output logic underflow
);
	import ffup_pkg::*;

	logic signed [TEXP_W-1:0] sumExp;

	// ----------------------------------------
	// bias and range
	// ----------------------------------------
	// RULE_06 bias added
	assign sumExp = trueExp + EXP_BIAS;
	assign biasedExp = sumExp[EXP_W-1:0];
	// RULE_10 range limits
	assign overflow = (trueExp > EXP_TRUE_MAX);
	assign underflow = (trueExp < EXP_TRUE_MIN);
endmodule : ffup_exp_check

/* File: rtl/ffup_top.sv */
// floating word unpack and pack unit, one cycle per direction
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Single words carry a 22-bit stored mantissa and double words a 54-bit one.
// RULE_02 - The exponent field is 9 bits wide in both formats.
// RULE_03 - The sign comes from bit 31 of a single word and bit 63 of a double word.
// RULE_04 - The mantissa is a fraction whose normalized top bit is one, so it lies in [1/2, 1).
// RULE_05 - Stored words omit the leading one, which unpack inserts and pack strips.
// RULE_06 - The stored exponent is the true exponent plus 256, so code 0x100 means zero.
// RULE_07 - Usable true exponents run from -255 to +255, codes 0x001 to 0x1ff.
// RULE_08 - An all-zero exponent field makes the whole operand zero regardless of other bits.
// RULE_09 - Zero is packed as a word with every bit cleared.
// RULE_10 - Pack flags overflow above +255 and underflow below -255.
// RULE_11 - Single words hold exponent 30:22 and mantissa 21:0; double words exponent 62:54.
module ffup_top (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic unpackValid,
	input wire logic unpackDouble,
	input wire logic [63:0] unpackWord,
	output logic unpValid,
	output logic unpSign,
	output logic [ffup_pkg::EXP_W-1:0] unpExp,
	output logic [9:0] unpTrueExp,
	output logic [ffup_pkg::MANT_W-1:0] unpMant,
	output logic unpZero,
	input wire logic packValid,
	input wire logic packDouble,
	input wire logic packSign,
	input wire logic signed [ffup_pkg::TEXP_W-1:0] packTrueExp,
	input wire logic [ffup_pkg::MANT_W-1:0] packMant,
	output logic packDone,
	output logic [63:0] packWord,
	output logic packZero,
	output logic packOverflow,
	output logic packUnderflow
);
	import ffup_pkg::*;

	typedef struct packed {
		logic uValid;
		logic uSign;
		logic [EXP_W-1:0] uExp;
		logic [9:0] uTrue;
		logic [MANT_W-1:0] uMant;
		logic uZero;
		logic pDone;
		logic [63:0] pWord;
		logic pZero;
		logic pOver;
		logic pUnder;
	} ffup_state_t;

	localparam ffup_state_t STATE_RST = '{
		uValid: 1'b0, uSign: 1'b0, uExp: EXP_ZERO_CODE, uTrue: 10'h0,
		uMant: MANT_RST, uZero: 1'b0, pDone: 1'b0, pWord: WORD_RST,
		pZero: 1'b0, pOver: 1'b0, pUnder: 1'b0};

	ffup_state_t state_reg;
	ffup_state_t state_next;
	logic [EXP_W-1:0] packBiased;
	logic expOver;
	logic expUnder;
	logic [EXP_W-1:0] inExp;
	logic [DP_MANT_W-1:0] inFrac;
	logic inSign;
	logic [DP_MANT_W-1:0] packFrac;

	// ----------------------------------------
	// pack exponent check
	// ----------------------------------------
	ffup_exp_check u_exp_check (
		.trueExp(packTrueExp),
		.biasedExp(packBiased),
		.overflow(expOver),
		.underflow(expUnder)
	);

	assign packFrac = packMant[DP_MANT_W-1:0];

	// field split of the incoming stored word
	always_comb begin
		// RULE_11 field positions
		if (unpackDouble) begin
			// RULE_03 double sign bit
			inSign = unpackWord[DP_SIGN_BIT];
			// RULE_02 nine bit exponent
			inExp = unpackWord[DP_EXP_MSB:DP_EXP_LSB];
			// RULE_01 double mantissa width
			inFrac = unpackWord[DP_MANT_W-1:0];
		end else begin
			// RULE_03 single sign bit
			inSign = unpackWord[SP_SIGN_BIT];
			inExp = unpackWord[SP_EXP_MSB:SP_EXP_LSB];
			// RULE_01 single mantissa left aligned
			inFrac = {unpackWord[SP_MANT_W-1:0], 32'h0};
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.uValid = unpackValid;
		state_next.pDone = packValid;
		// unpack path
		if (unpackValid) begin
			if (inExp == EXP_ZERO_CODE) begin
				// RULE_08 zero exponent forces zero
				state_next.uSign = 1'b0;
				state_next.uExp = EXP_ZERO_CODE;
				state_next.uTrue = 10'h0;
				state_next.uMant = MANT_RST;
				state_next.uZero = 1'b1;
			end else begin
				state_next.uSign = inSign;
				state_next.uExp = inExp;
				// RULE_06 remove bias
				// RULE_07 codes 001 to 1ff give -255 to +255
				state_next.uTrue = {1'b0, inExp} - EXP_BIAS10;
				// RULE_04 normalized fraction, top bit one
				// RULE_05 insert hidden one
				state_next.uMant = {1'b1, inFrac};
				state_next.uZero = 1'b0;
			end
		end
		// pack path
		if (packValid) begin
			state_next.pOver = expOver;
			state_next.pUnder = expUnder;
			state_next.pZero = 1'b0;
			if (!packMant[MANT_W-1] || expUnder) begin
				// RULE_09 zero word all bits clear
				state_next.pWord = WORD_RST;
				state_next.pZero = 1'b1;
			end else if (expOver) begin
				// saturate at largest magnitude, keep sign
				if (packDouble) begin
					state_next.pWord = {packSign, EXP_SAT_CODE, {DP_MANT_W{1'b1}}};
				end else begin
					state_next.pWord = {32'h0, packSign, EXP_SAT_CODE, {SP_MANT_W{1'b1}}};
				end
			end else if (packDouble) begin
				// RULE_05 strip hidden one
				// RULE_11 double layout
				state_next.pWord = {packSign, packBiased, packFrac};
			end else begin
				// RULE_11 single layout, upper half clear
				state_next.pWord = {32'h0, packSign, packBiased,
					packFrac[DP_MANT_W-1 -: SP_MANT_W]};
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= STATE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign unpValid = state_reg.uValid;
	assign unpSign = state_reg.uSign;
	assign unpExp = state_reg.uExp;
	assign unpTrueExp = state_reg.uTrue;
	assign unpMant = state_reg.uMant;
	assign unpZero = state_reg.uZero;
	assign packDone = state_reg.pDone;
	assign packWord = state_reg.pWord;
	assign packZero = state_reg.pZero;
	assign packOverflow = state_reg.pOver;
	assign packUnderflow = state_reg.pUnder;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// RULE_08 zero operand check
	a_unpack_zero_op: assert property ( // RULE_08
		@(posedge ref_clk) disable iff (reset)
		unpackValid && !unpackDouble && unpackWord[SP_EXP_MSB:SP_EXP_LSB] == EXP_ZERO_CODE
		|=> unpZero && unpMant == MANT_RST && !unpSign)
		else $error("zero exponent did not give a zero operand");

	// RULE_05 hidden one present
	a_hidden_one: assert property ( // RULE_05
		@(posedge ref_clk) disable iff (reset)
		unpValid && !unpZero |-> unpMant[MANT_W-1] && unpExp != EXP_ZERO_CODE)
		else $error("unpacked mantissa lacks the leading one");

	// RULE_03 single sign source
	a_sign_single: assert property ( // RULE_03
		@(posedge ref_clk) disable iff (reset)
		unpackValid && !unpackDouble && unpackWord[SP_EXP_MSB:SP_EXP_LSB] != EXP_ZERO_CODE
		|=> unpSign == $past(unpackWord[SP_SIGN_BIT]))
		else $error("single sign not taken from bit 31");

	// RULE_03 double sign source
	a_sign_double: assert property ( // RULE_03
		@(posedge ref_clk) disable iff (reset)
		unpackValid && unpackDouble && unpackWord[DP_EXP_MSB:DP_EXP_LSB] != EXP_ZERO_CODE
		|=> unpSign == $past(unpackWord[DP_SIGN_BIT]))
		else $error("double sign not taken from bit 63");

	// RULE_06 bias code means zero
	a_bias_zero: assert property ( // RULE_06
		@(posedge ref_clk) disable iff (reset)
		unpackValid && unpackDouble && unpackWord[DP_EXP_MSB:DP_EXP_LSB] == 9'h100
		|=> unpTrueExp == 10'h0 && unpExp == 9'h100)
		else $error("exponent code 0x100 is not true zero");

	// RULE_10 overflow flag
	a_exp_overflow: assert property ( // RULE_10
		@(posedge ref_clk) disable iff (reset)
		packValid && packMant[MANT_W-1] && packTrueExp > 11'sh0ff
		|=> packOverflow && packDone && !packZero
		 && packWord[SP_EXP_MSB:SP_EXP_LSB] == EXP_SAT_CODE)
		else $error("overflow not flagged above +255");

	// RULE_10 underflow flag
	a_exp_underflow: assert property ( // RULE_10
		@(posedge ref_clk) disable iff (reset)
		packValid && packTrueExp < -11'sh0ff |=> packUnderflow && packWord == 64'h0)
		else $error("underflow not flagged below -255");

	// RULE_09 zero word
	a_zero_word: assert property ( // RULE_09
		@(posedge ref_clk) disable iff (reset)
		packValid && !packMant[MANT_W-1] |=> packZero && packDone && packWord == 64'h0)
		else $error("zero result is not an all clear word");

	// RULE_11 double layout
	a_double_layout: assert property ( // RULE_11
		@(posedge ref_clk) disable iff (reset)
		packValid && packDouble && packMant[MANT_W-1] && !expOver && !expUnder
		|=> packWord[DP_MANT_W-1:0] == $past(packFrac)
		 && packWord[DP_EXP_MSB:DP_EXP_LSB] == $past(packBiased))
		else $error("double word fields misplaced");

	// pack done follows each request one cycle later
	a_pack_pulse: assert property (
		@(posedge ref_clk) disable iff (reset)
		packValid |=> packDone ##1 (packDone == $past(packValid)))
		else $error("pack done does not follow request by one cycle");
endmodule : ffup_top

/* File: tb/ffup_arith_model.sv */
// far-side arithmetic model that returns unpacked operands for packing
`timescale 1ns/1ps
module ffup_arith_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic resValid,
	input wire logic resSign,
	input wire logic [9:0] resTrueExp,
	input wire logic [54:0] resMant,
	input wire logic signed [10:0] expAdj,
	input wire logic slow,
	output logic reqValid,
	output logic reqSign,
	output logic signed [10:0] reqExp,
	output logic [54:0] reqMant
);
	logic [66:0] pend[$];
	int waitCnt;
	// ---
	// operand queue
	// ---
	// keeps the hidden one
	always @(negedge ref_clk or posedge reset) begin
		if (reset) begin
			pend.delete();
			{reqValid, reqSign, reqExp, reqMant} = '0;
			waitCnt = 0;
		end else begin
			if (resValid)
				pend.push_back({resSign, $signed({resTrueExp[9], resTrueExp}) + expAdj, resMant});
			waitCnt++;
			if (pend.size() > 0 && (!slow || waitCnt > 3)) begin
				{reqSign, reqExp, reqMant} = pend.pop_front();
				reqValid = 1'b1;
				waitCnt = 0;
			end else begin
				// released lines do not keep the old value
				{reqSign, reqExp, reqMant} = ~{reqSign, reqExp, reqMant};
				reqValid = 1'b0;
			end
		end
	end
endmodule : ffup_arith_model

/* File: tb/tb_float_format_unpack_pack.sv */
// self-checking bench for the floating word unpack and pack unit
`timescale 1ns/1ps
module tb_float_format_unpack_pack;
	import ffup_pkg::*;
	logic ref_clk, reset, unpackValid, unpackDouble, unpValid, unpSign, unpZero, packValid;
	logic packDouble, packSign, packDone, packZero, packOverflow, packUnderflow, slow;
	logic uTaken, pTaken;
	logic [63:0] unpackWord, packWord, w;
	logic [EXP_W-1:0] unpExp, e;
	logic [9:0] unpTrueExp;
	logic [MANT_W-1:0] unpMant, packMant;
	logic signed [TEXP_W-1:0] packTrueExp, expAdj;
	logic [75:0] uq[$];
	logic [66:0] pq[$];
	logic [75:0] uE;
	logic [66:0] pE;
	int adjTab[8] = '{0, 1, -1, 300, -300, 255, -255, 2};
	logic [8:0] expTab[4] = '{9'h000, 9'h001, 9'h100, 9'h1ff};
	int n_mismatch = 0;
	int num_checks = 0;
	int k;

	ffup_top uut (.ref_clk(ref_clk), .reset(reset), .unpackValid(unpackValid),
		.unpackDouble(unpackDouble), .unpackWord(unpackWord), .unpValid(unpValid),
		.unpSign(unpSign), .unpExp(unpExp), .unpTrueExp(unpTrueExp), .unpMant(unpMant),
		.unpZero(unpZero), .packValid(packValid), .packDouble(packDouble),
		.packSign(packSign), .packTrueExp(packTrueExp), .packMant(packMant),
		.packDone(packDone), .packWord(packWord), .packZero(packZero),
		.packOverflow(packOverflow), .packUnderflow(packUnderflow));
	ffup_arith_model arith (.ref_clk(ref_clk), .reset(reset), .resValid(unpValid),
		.resSign(unpSign), .resTrueExp(unpTrueExp), .resMant(unpMant), .expAdj(expAdj),
		.slow(slow), .reqValid(packValid), .reqSign(packSign), .reqExp(packTrueExp),
		.reqMant(packMant));

	// ---
	// reference model and checks
	// ---
	function automatic logic [75:0] unpExpect(logic d, logic [63:0] x);
		logic [8:0] f;
		f = d ? x[62:54] : x[30:22];
		if (f == 9'h0)
			return 76'h1;
		return {d ? x[63] : x[31], f, {1'b0, f} - 10'h100,
			d ? {1'b1, x[53:0]} : {1'b1, x[21:0], 32'h0}, 1'b0};
	endfunction : unpExpect

	function automatic logic [66:0] packExpect(logic d, logic s, int te, logic [54:0] m);
		logic z, ov, un;
		logic [8:0] be;
		logic [63:0] r;
		ov = te > 255;
		un = te < -255;
		z = !m[54] || un;
		be = ov ? 9'h1ff : 9'(te + 256);
		if (ov)
			m = '1;
		r = d ? {s, be, m[53:0]} : {32'h0, s, be, m[53:32]};
		if (z)
			r = '0;
		return {r, z, ov, un};
	endfunction : packExpect

	task automatic chk(logic [127:0] got, logic [127:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rstChk();
		chk({unpValid, unpSign, unpExp, unpTrueExp, unpMant, unpZero}, 0);
		chk({packDone, packWord, packZero, packOverflow, packUnderflow}, 0);
	endtask : rstChk

	task automatic results();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// record requests taken at the rising edge
	always @(posedge ref_clk) begin
		uTaken <= !reset && unpackValid;
		pTaken <= !reset && packValid;
		if (!reset && unpackValid)
			uq.push_back(unpExpect(unpackDouble, unpackWord));
		if (!reset && packValid)
			pq.push_back(packExpect(packDouble, packSign, packTrueExp, packMant));
	end

	// compare results one cycle after each request
	always @(negedge ref_clk) begin
		if (reset) begin
			uq.delete();
			pq.delete();
		end else begin
			chk(unpValid, uTaken);
			chk(packDone, pTaken);
			if (unpValid === 1'b1 && uq.size() > 0) begin
				uE = uq.pop_front();
				chk({unpSign, unpExp, unpTrueExp}, uE[75:56]);
				chk(unpMant, uE[55:1]);
				chk(unpZero, uE[0]);
			end
			if (packDone === 1'b1 && pq.size() > 0) begin
				pE = pq.pop_front();
				chk(packWord, pE[66:3]);
				chk({packZero, packOverflow, packUnderflow}, pE[2:0]);
			end
		end
	end

	// random words with boundary exponents, a reset in mid-run
	initial begin
		reset = 1'b1;
		{unpackValid, unpackDouble, unpackWord, packDouble, expAdj, slow} = '0;
		repeat (10) @(negedge ref_clk);
		rstChk();
		reset <= 1'b0;
		void'($urandom(32'hb45a));
		for (int i = 0; i < 600; i++) begin
			@(negedge ref_clk);
			if (i == 300) begin
				reset <= 1'b1;
				@(negedge ref_clk);
				rstChk();
				reset <= 1'b0;
			end
			slow <= (i % 50) < 10;
			expAdj <= 11'(adjTab[i / 75]);
			packDouble <= i[4];
			unpackValid <= ($urandom % 4) != 0;
			unpackDouble <= 1'($urandom);
			w = {$urandom, $urandom};
			e = expTab[$urandom % 4];
			if ($urandom % 2) begin
				w[62:54] = e;
				w[30:22] = e;
			end
			unpackWord <= w;
		end
		unpackValid <= 1'b0;
		for (k = 0; k < 300 && (uq.size() + pq.size() + arith.pend.size()) > 0; k++)
			@(negedge ref_clk);
		if (k == 300)
			n_mismatch++;
		repeat (3) @(negedge ref_clk);
		results();
	end
endmodule : tb_float_format_unpack_pack
